// >>> design/cmx_sel.v
// Comparator input routing and blanking mask source selection with Avalon-MM registers.
// Notes on behaviour
// - Reference select set routes non-inverting input to internal reference voltage.
// - Reference select clear routes non-inverting input to pin A.
// - Channel field 11 connects inverting input to internal reference source.
// - Channel field 10 pin D, 01 pin C, 00 pin B.
// - Control bits 15 to 5, 3 and 2 ignore writes and read zero.
// - Mask codes 0..5 pick generator 1..3 low/high; 6..15 reserved.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "cmx_sel_defines.vh"

module cmx_sel (
  input wire clk,
  input wire rstn,
  input wire [`CMX_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  input wire comparator_pin_a,
  input wire comparator_pin_b,
  input wire comparator_pin_c,
  input wire comparator_pin_d,
  input wire internal_reference_voltage,
  input wire internal_reference_source,
  input wire pwm_gen1_low,
  input wire pwm_gen1_high,
  input wire pwm_gen2_low,
  input wire pwm_gen2_high,
  input wire pwm_gen3_low,
  input wire pwm_gen3_high,
  output reg vinPlus_ff,
  output reg vinMinus_ff,
  output reg maskA_ff,
  output reg maskB_ff,
  output reg maskC_ff,
  output reg [15:0] controlOut_ff,
  output reg [15:0] maskSrcOut_ff
);

  // Register images and the acknowledge flag of the bus slave.
  reg [15:0] ctl_ff;
  reg [15:0] msk_ff;
  reg ack_ff;
  // Next values of the register images and of the bus answer.
  reg [15:0] nxt_ctl;
  reg [15:0] nxt_msk;
  reg [31:0] nxt_readdata;
  reg [1:0] nxt_response;
  // Decoded bus fields and next values of the routed comparator inputs.
  reg [15:0] wrBits;
  reg [15:0] rdBits;
  reg rdHit;
  reg nxt_vinPlus;
  reg nxt_vinMinus;
  // Bus handshake terms and the three mask picks.
  wire req;
  wire take;
  wire commit;
  wire [5:0] pwmVec;
  wire pickA;
  wire pickB;
  wire pickC;

  // A request is present while either strobe is high.
  assign req = avs_read | avs_write;

  // A request is taken once; the edge after an acknowledge never takes it again, because
  // the master only drops its strobes at that edge.
  assign take = req & ~ack_ff;

  // A write lands at the edge where the master sees waitrequest low, and at no other.
  assign commit = ack_ff & avs_write;

  // The six generator outputs in code order, lowest code in the lowest bit.
  assign pwmVec = {pwm_gen3_high, pwm_gen3_low, pwm_gen2_high, pwm_gen2_low,
                   pwm_gen1_high, pwm_gen1_low};

  cmx_sel_mask_pick u_pickA (
    .code(msk_ff[`CMX_MSK_A_HI:`CMX_MSK_A_LO]),
    .src(pwmVec),
    .pick(pickA)
  );

  cmx_sel_mask_pick u_pickB (
    .code(msk_ff[`CMX_MSK_B_HI:`CMX_MSK_B_LO]),
    .src(pwmVec),
    .pick(pickB)
  );

  cmx_sel_mask_pick u_pickC (
    .code(msk_ff[`CMX_MSK_C_HI:`CMX_MSK_C_LO]),
    .src(pwmVec),
    .pick(pickC)
  );

  // Byte lanes 0 and 1 cover the sixteen register bits; lanes 2 and 3 have nothing behind them.
  always @* begin
    wrBits = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end

  // Address decode for reads; an unmapped address reads zero and is flagged.
  always @* begin
    rdBits = 16'h0000;
    rdHit = 1'b1;
    case (avs_address)
      `CMX_ADDR_CONTROL: begin
        rdBits = ctl_ff;
      end
      `CMX_ADDR_MASKSRC: begin
        rdBits = msk_ff;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // Control register merge; only the reference bit and the channel field can take a one.
  always @* begin
    nxt_ctl = ctl_ff;
    if (avs_address == `CMX_ADDR_CONTROL) begin
      nxt_ctl = ((ctl_ff & ~wrBits) | (avs_writedata[15:0] & wrBits)) & `CMX_CTL_WMASK;
    end
  end

  // Mask source register merge; the top nibble can never take a one.
  always @* begin
    nxt_msk = msk_ff;
    if (avs_address == `CMX_ADDR_MASKSRC) begin
      nxt_msk = ((msk_ff & ~wrBits) | (avs_writedata[15:0] & wrBits)) & `CMX_MSK_WMASK;
    end
  end

  // Bus answer: read data padded to the word, and an error code for an unmapped address.
  always @* begin
    nxt_readdata = {16'h0000, rdBits};
    if (rdHit) begin
      nxt_response = `CMX_RESP_OKAY;
    end else begin
      nxt_response = `CMX_RESP_SLVERR;
    end
  end

  // Non-inverting input steering.
  always @* begin
    if (ctl_ff[`CMX_CTL_REF_BIT]) begin
      nxt_vinPlus = internal_reference_voltage;
    end else begin
      nxt_vinPlus = comparator_pin_a;
    end
  end

  // Inverting input steering; all four codes are used, so the default is only a safe low.
  always @* begin
    case (ctl_ff[`CMX_CTL_CH_HI:`CMX_CTL_CH_LO])
      `CMX_CH_PIN_B: begin
        nxt_vinMinus = comparator_pin_b;
      end
      `CMX_CH_PIN_C: begin
        nxt_vinMinus = comparator_pin_c;
      end
      `CMX_CH_PIN_D: begin
        nxt_vinMinus = comparator_pin_d;
      end
      `CMX_CH_INTERNAL_REFERENCE_SOURCE: begin
        nxt_vinMinus = internal_reference_source;
      end
      default: begin
        nxt_vinMinus = 1'b0;
      end
    endcase
  end

  // Acknowledge flag: set for the one cycle after a request is taken.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // Waitrequest: high at rest and in reset, low for exactly one cycle of acknowledge.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~take;
    end
  end

  // Read data and response are loaded when a request is taken and stand through the answer.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= `CMX_RDATA_RESET;
      avs_response <= `CMX_RESP_OKAY;
    end else if (take) begin
      avs_readdata <= nxt_readdata;
      avs_response <= nxt_response;
    end
  end

  // Register images are written only at the accepting edge; a write to an unmapped address
  // leaves both untouched.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= `CMX_CTL_RESET;
      msk_ff <= `CMX_MSK_RESET;
    end else if (commit) begin
      ctl_ff <= nxt_ctl;
      msk_ff <= nxt_msk;
    end
  end

  // Routed comparator inputs, one cycle behind the pins and the control register.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vinPlus_ff <= 1'b0;
      vinMinus_ff <= 1'b0;
    end else begin
      vinPlus_ff <= nxt_vinPlus;
      vinMinus_ff <= nxt_vinMinus;
    end
  end

  // Blanking mask outputs, one cycle behind the generators and the mask source register.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      maskA_ff <= 1'b0;
      maskB_ff <= 1'b0;
      maskC_ff <= 1'b0;
    end else begin
      maskA_ff <= pickA;
      maskB_ff <= pickB;
      maskC_ff <= pickC;
    end
  end

  // Register image outputs, so the rest of the device sees the settings without the bus.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      controlOut_ff <= `CMX_CTL_RESET;
      maskSrcOut_ff <= `CMX_MSK_RESET;
    end else begin
      controlOut_ff <= ctl_ff;
      maskSrcOut_ff <= msk_ff;
    end
  end

endmodule // cmx_sel

// One blanking mask selector: turns a four-bit source code into one generator output.
module cmx_sel_mask_pick #(
  parameter CODE_W = 4,
  parameter SRC_N = 6
) (
  input wire [CODE_W-1:0] code,
  input wire [SRC_N-1:0] src,
  output reg pick
);

  // Codes zero to five name a generator output; a stray reserved code yields a quiet low.
  // mask source codes
  always @* begin
    case (code)
      `CMX_SRC_G1_LOW: begin
        pick = src[0];
      end
      `CMX_SRC_G1_HIGH: begin
        pick = src[1];
      end
      `CMX_SRC_G2_LOW: begin
        pick = src[2];
      end
      `CMX_SRC_G2_HIGH: begin
        pick = src[3];
      end
      `CMX_SRC_G3_LOW: begin
        pick = src[4];
      end
      `CMX_SRC_G3_HIGH: begin
        pick = src[5];
      end
      default: begin
        pick = 1'b0; // Reserved codes never blank the comparator by themselves.
      end
    endcase
  end

endmodule // cmx_sel_mask_pick

// >>> design/cmx_sel_defines.vh
// Constants for the comparator input and mask source selection block.
`ifndef CMX_SEL_DEFINES_VH
`define CMX_SEL_DEFINES_VH
// Register byte addresses on the Avalon-MM word bus.
`define CMX_ADDR_CONTROL 4'h0
`define CMX_ADDR_MASKSRC 4'h4
`define CMX_ADDR_W 4
// Control register fields.
`define CMX_CTL_REF_BIT 4
`define CMX_CTL_CH_HI 1
`define CMX_CTL_CH_LO 0
`define CMX_CTL_WMASK 16'h0013
// Mask source register fields.
`define CMX_MSK_A_HI 3
`define CMX_MSK_A_LO 0
`define CMX_MSK_B_HI 7
`define CMX_MSK_B_LO 4
`define CMX_MSK_C_HI 11
`define CMX_MSK_C_LO 8
`define CMX_MSK_WMASK 16'h0FFF
// Reset values.
`define CMX_CTL_RESET 16'h0000
`define CMX_MSK_RESET 16'h0000
`define CMX_RDATA_RESET 32'h00000000
// Bus response codes.
`define CMX_RESP_OKAY 2'h0
`define CMX_RESP_SLVERR 2'h2
// Inverting channel codes.
`define CMX_CH_PIN_B 2'h0
`define CMX_CH_PIN_C 2'h1
`define CMX_CH_PIN_D 2'h2
`define CMX_CH_INTERNAL_REFERENCE_SOURCE 2'h3
// Mask source codes.
`define CMX_SRC_G1_LOW 4'h0
`define CMX_SRC_G1_HIGH 4'h1
`define CMX_SRC_G2_LOW 4'h2
`define CMX_SRC_G2_HIGH 4'h3
`define CMX_SRC_G3_LOW 4'h4
`define CMX_SRC_G3_HIGH 4'h5
`endif

// >>> testbench/cmx_sel_props.sv
// Assertions on the routed outputs and register images of the selection block.
`timescale 1ns/1ps
module cmx_sel_props (
  input wire clk,
  input wire rstn,
  input wire vinPlus_ff,
  input wire vinMinus_ff,
  input wire maskA_ff,
  input wire maskB_ff,
  input wire maskC_ff,
  input wire comparator_pin_a,
  input wire comparator_pin_b,
  input wire comparator_pin_c,
  input wire comparator_pin_d,
  input wire internal_reference_voltage,
  input wire internal_reference_source,
  input wire pwm_gen1_low,
  input wire pwm_gen1_high,
  input wire pwm_gen2_low,
  input wire pwm_gen2_high,
  input wire pwm_gen3_low,
  input wire pwm_gen3_high,
  input wire [15:0] controlOut_ff,
  input wire [15:0] maskSrcOut_ff
);
  reg [11:0] inQ_ff;
  // Holds the inputs as the registered outputs saw them one edge earlier.
  always @(posedge clk) inQ_ff <= {pwm_gen3_high, pwm_gen3_low, pwm_gen2_high, pwm_gen2_low,
    pwm_gen1_high, pwm_gen1_low, internal_reference_source, internal_reference_voltage,
    comparator_pin_d, comparator_pin_c, comparator_pin_b, comparator_pin_a};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_plus_ref: assert property ($past(rstn) && controlOut_ff[4] |->
    vinPlus_ff == inQ_ff[4]) else $error("plus input not on the reference");
  a_plus_pin: assert property ($past(rstn) && !controlOut_ff[4] |->
    vinPlus_ff == inQ_ff[0]) else $error("plus input not on pin a");
  a_minus_ref: assert property ($past(rstn) && controlOut_ff[1:0] == 2'h3 |->
    vinMinus_ff == inQ_ff[5]) else $error("minus input not on the reference");
  a_minus_pin: assert property ($past(rstn) && controlOut_ff[1:0] != 2'h3 |->
    vinMinus_ff == inQ_ff[controlOut_ff[1:0] + 1]) else $error("minus input on wrong pin");
  a_ctl_zero: assert property ((controlOut_ff & 16'hFFEC) == 16'h0000)
    else $error("unused control bits set");
  a_mask_a: assert property ($past(rstn) |-> maskA_ff ==
    (maskSrcOut_ff[3:0] < 4'h6 && inQ_ff[6 + maskSrcOut_ff[3:0]])) else $error("mask a wrong");
  a_mask_bc: assert property ($past(rstn) |-> maskSrcOut_ff[15:12] == 4'h0 &&
    maskB_ff == (maskSrcOut_ff[7:4] < 4'h6 && inQ_ff[6 + maskSrcOut_ff[7:4]]) &&
    maskC_ff == (maskSrcOut_ff[11:8] < 4'h6 && inQ_ff[6 + maskSrcOut_ff[11:8]]))
    else $error("mask b or c wrong");
endmodule // cmx_sel_props
bind cmx_sel cmx_sel_props u_props (
  .clk(clk),
  .rstn(rstn),
  .vinPlus_ff(vinPlus_ff),
  .vinMinus_ff(vinMinus_ff),
  .maskA_ff(maskA_ff),
  .maskB_ff(maskB_ff),
  .maskC_ff(maskC_ff),
  .comparator_pin_a(comparator_pin_a),
  .comparator_pin_b(comparator_pin_b),
  .comparator_pin_c(comparator_pin_c),
  .comparator_pin_d(comparator_pin_d),
  .internal_reference_voltage(internal_reference_voltage),
  .internal_reference_source(internal_reference_source),
  .pwm_gen1_low(pwm_gen1_low),
  .pwm_gen1_high(pwm_gen1_high),
  .pwm_gen2_low(pwm_gen2_low),
  .pwm_gen2_high(pwm_gen2_high),
  .pwm_gen3_low(pwm_gen3_low),
  .pwm_gen3_high(pwm_gen3_high),
  .controlOut_ff(controlOut_ff),
  .maskSrcOut_ff(maskSrcOut_ff)
);

// >>> testbench/tb_cmx_sel.sv
// Self-checking bench for the comparator selection block.
`timescale 1ns/1ps
`include "cmx_sel_defines.vh"
module tb_cmx_sel;
  reg clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
  reg [3:0] avs_address = 0;
  reg [3:0] be = 4'hF;
  reg [31:0] avs_writedata = 0;
  reg [11:0] p = 0;
  reg [15:0] v;
  reg [33:0] rdData;
  wire [31:0] avs_readdata;
  wire [15:0] controlOut_ff, maskSrcOut_ff;
  wire [1:0] avs_response;
  wire avs_waitrequest, vinPlus_ff, vinMinus_ff, maskA_ff, maskB_ff, maskC_ff;
  integer seed = 51642, failures = 0, checked = 0, i, c;
  // Device with its pin and generator inputs taken from one random vector.
  cmx_sel u_dut (
    .clk(clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(be),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response),
    .comparator_pin_a(p[0]),
    .comparator_pin_b(p[1]),
    .comparator_pin_c(p[2]),
    .comparator_pin_d(p[3]),
    .internal_reference_voltage(p[4]),
    .internal_reference_source(p[5]),
    .pwm_gen1_low(p[6]),
    .pwm_gen1_high(p[7]),
    .pwm_gen2_low(p[8]),
    .pwm_gen2_high(p[9]),
    .pwm_gen3_low(p[10]),
    .pwm_gen3_high(p[11]),
    .vinPlus_ff(vinPlus_ff),
    .vinMinus_ff(vinMinus_ff),
    .maskA_ff(maskA_ff),
    .maskB_ff(maskB_ff),
    .maskC_ff(maskC_ff),
    .controlOut_ff(controlOut_ff),
    .maskSrcOut_ff(maskSrcOut_ff)
  );
  // Clock of 8 ns period.
  always #4 clk = ~clk;
  // One bus cycle held until waitrequest is seen low; response and data taken then.
  task bus(input w, input [3:0] a, input [15:0] d);
    integer n;
    begin
      n = 0;
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        @(posedge clk);
        n++;
      end
      if (n == 20) begin
        failures++;
        final_report;
      end
      rdData = {avs_response, avs_readdata};
      avs_write <= 0;
      avs_read <= 0;
      @(posedge clk);
    end
  endtask
  task chk(input [33:0] s, input [33:0] e);
    begin
      checked++;
      if (s !== e) begin
        failures++;
        $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Routing, mask and unmapped access tests.
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    bus(0, `CMX_ADDR_MASKSRC, 0);
    chk(rdData, 0);
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[4] = i[2];
      v[1:0] = i[1:0];
      c = v[1:0];
      p <= $random(seed);
      bus(1, `CMX_ADDR_CONTROL, v);
      bus(0, `CMX_ADDR_CONTROL, 0);
      chk(rdData, v & 16'h0013);
      chk(vinPlus_ff, v[4] ? p[4] : p[0]);
      chk(vinMinus_ff, c == 3 ? p[5] : p[c + 1]);
    end
    $display("routing test done");
    be <= 4'h1;
    bus(1, `CMX_ADDR_CONTROL, 16'hFFFF);
    be <= 4'h2;
    bus(1, `CMX_ADDR_CONTROL, 16'h0000);
    be <= 4'hF;
    bus(0, `CMX_ADDR_CONTROL, 0);
    chk(rdData, 34'h000000013);
    $display("byte lane test done");
    for (i = 0; i < 16; i++) begin
      v = {4'hF, i[3:0], 4'hF - i[3:0], i[3:0]};
      p <= $random(seed);
      bus(1, `CMX_ADDR_MASKSRC, v);
      bus(0, `CMX_ADDR_MASKSRC, 0);
      chk(rdData, v & 16'h0FFF);
      chk(maskA_ff, i < 6 && p[6 + i]);
      chk({maskC_ff, maskB_ff}, {i < 6 && p[6 + i], 15 - i < 6 && p[21 - i]});
    end
    $display("mask test done");
    bus(0, 4'h8, 0);
    chk(rdData, 34'h200000000);
    $display("unmapped test done");
    final_report;
  end
  // Cuts a hang short long after the tests should have ended.
  initial begin
    #100000;
    failures++;
    final_report;
  end
endmodule // tb_cmx_sel
